// ===== core/nhp_port.v
// Four-bit host port of the tone transceiver, two host styles.
// Assumes a 25 MHz clk; all bus pins are asynchronous and oversampled.
//
// Summary of operation
// - Separate-strobe style: with chip select and read strobe low, the addressed register drives the data lines.
// - Separate-strobe style: the write strobe stores the data lines into the addressed register while chip select is low.
// - Separate-strobe style: the address is taken from data lines 1..0 on the falling edge of the address latch strobe.
// - The data bus is four bits, two-way, and in separate-strobe style its two low lines also carry the address.
// - Clocked style: in write direction the data lines are stored on the falling edge of the strobe clock.
// - Clocked style: in read direction the selected register drives the lines while the strobe clock is high.
// - Clocked style: the strobe clock may be irregular, so only its edges are used, never its period.
// - Clocked style: address high selects control write and status read, low selects tone transmit and receive.
// - Clocked style: direction high means read, low means write.
// - All transfers are ignored while chip select is high.
// - The call tone detect output is high while the detector reports a valid 400 Hz tone.
// - With the detect output enable bit at zero the call tone detect output is held low.
// - The tone generator output follows the tone transmit enable bit of the control register.
// - While power down is high, control and tone transmit registers clear and detection reads as absent.
`timescale 1ns/100ps
`default_nettype none
`include "nhp_defs.vh"

module nhp_port #(
  parameter DATA_W = `NHP_DATA_W,
  parameter FLAG_W = `NHP_FLAG_W
) (
  input wire clk,
  input wire sys_rst,
  input wire host_style_strap,
  input wire power_down_input,
  input wire cs_n,
  input wire read_n,
  input wire ale,
  input wire wr_n,
  input wire [DATA_W-1:0] data_in,
  output reg [DATA_W-1:0] data_out,
  output reg data_oe,
  input wire call_tone_valid,
  input wire [FLAG_W-1:0] status_flags,
  input wire [DATA_W-1:0] tone_receive_register,
  output reg [DATA_W-1:0] control_register,
  output reg [DATA_W-1:0] tone_transmit_register,
  output reg tone_tx_load,
  output reg tone_transmit_enable,
  output reg detect_output_enable,
  output reg tone_gen_analog_out,
  output reg call_tone_detect_out,
  output reg style_strobe
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire cs_n_s;
  wire read_s;
  wire ale_s;
  wire wr_s;
  wire strap_s;
  wire pd_s;
  wire [DATA_W-1:0] data_s;

  nhp_sync #(.W(4), .RESET_VAL(4'hf)) u_sync_ctl (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({cs_n, read_n, wr_n, power_down_input}),
    .sync_out({cs_n_s, read_s, wr_s, pd_s})
  );

  nhp_sync #(.W(2), .RESET_VAL(2'h2)) u_sync_cfg (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({host_style_strap, ale}),
    .sync_out({strap_s, ale_s})
  );

  nhp_sync #(.W(DATA_W), .RESET_VAL({DATA_W{1'b0}})) u_sync_data (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(data_in),
    .sync_out(data_s)
  );

  // ----------------------------------------
  // Edge finders
  // ----------------------------------------
  // Edges only, so an irregular strobe clock works
  wire read_rise;
  wire read_fall;
  wire wr_rise;
  wire ale_fall;

  nhp_edge #(.RESET_VAL(1'b1)) u_edge_read (
    .clk(clk),
    .sys_rst(sys_rst),
    .level(read_s),
    .rise(read_rise),
    .fall(read_fall)
  );

  nhp_edge #(.RESET_VAL(1'b1)) u_edge_wr (
    .clk(clk),
    .sys_rst(sys_rst),
    .level(wr_s),
    .rise(wr_rise),
    .fall()
  );

  nhp_edge #(.RESET_VAL(1'b0)) u_edge_ale (
    .clk(clk),
    .sys_rst(sys_rst),
    .level(ale_s),
    .rise(),
    .fall(ale_fall)
  );

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  // Waits for the synchroniser to flush its reset value
  reg [1:0] settle;
  reg ready;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      settle <= 2'h0;
      ready <= 1'b0;
      style_strobe <= `NHP_STYLE_STROBE;
    end else if (!ready) begin
      settle <= settle + 2'h1;
      if (settle == `NHP_SETTLE_CYCLES) begin
        ready <= 1'b1;
        style_strobe <= strap_s;
      end
    end
  end

  // ----------------------------------------
  // Address latch
  // ----------------------------------------
  // Address latches with chip select high too
  reg [`NHP_ADDR_W-1:0] addr;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr <= `NHP_ADDR_RESET;
    end else if (ready && style_strobe && ale_fall) begin
      addr <= data_s[`NHP_ADDR_W-1:0];
    end
  end

  // ----------------------------------------
  // Strobe write capture
  // ----------------------------------------
  // Select and data are taken while the write strobe is low, so a host
  // that lets go of chip select or data with the strobe still writes
  reg wr_armed;
  reg [DATA_W-1:0] wr_data;
  wire [DATA_W-1:0] write_data;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_armed <= 1'b0;
      wr_data <= {DATA_W{1'b0}};
    end else if (!wr_s) begin
      wr_armed <= ready & style_strobe & ~cs_n_s;
      wr_data <= data_s;
    end else begin
      wr_armed <= 1'b0;
    end
  end

  // Clocked writes take live data, the strobe fall is their only moment
  assign write_data = style_strobe ? wr_data : data_s;

  // ----------------------------------------
  // Transfer decode
  // ----------------------------------------
  reg sel_ctrl;
  reg sel_tone;
  reg do_write;
  reg do_drive;

  always @* begin
    sel_ctrl = 1'b0;
    sel_tone = 1'b0;
    do_write = 1'b0;
    do_drive = 1'b0;
    if (!ready) begin
      do_write = 1'b0;
      do_drive = 1'b0;
    end else if (style_strobe) begin
      // Chip select was checked while the write strobe was low
      sel_ctrl = (addr == `NHP_ADDR_CTRL);
      sel_tone = (addr == `NHP_ADDR_TONE);
      do_write = wr_rise & wr_armed;
      do_drive = ~read_s & ~cs_n_s;
    end else begin
      sel_ctrl = ale_s;
      sel_tone = ~ale_s;
      do_write = read_fall & ~wr_s & ~cs_n_s;
      do_drive = read_s & wr_s & ~cs_n_s;
    end
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  reg [DATA_W-1:0] status_view;
  reg [DATA_W-1:0] receive_view;
  reg [DATA_W-1:0] next_data_out;

  always @* begin
    // Power down shows no detection and an empty receive code
    status_view = {status_flags, call_tone_valid};
    receive_view = tone_receive_register;
    if (pd_s) begin
      status_view = {DATA_W{1'b0}};
      receive_view = {DATA_W{1'b0}};
    end
    if (sel_ctrl) begin
      next_data_out = status_view;
    end else if (sel_tone) begin
      next_data_out = receive_view;
    end else begin
      next_data_out = `NHP_READ_IDLE;
    end
  end

  // ----------------------------------------
  // Bus drive
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= `NHP_READ_IDLE;
      data_oe <= 1'b0;
    end else begin
      data_oe <= do_drive;
      // Data keeps its last value while released, only the enable moves
      if (do_drive) begin
        data_out <= next_data_out;
      end
    end
  end

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  // Power down holds both registers clear and drops writes
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      control_register <= `NHP_CR_RESET;
      tone_transmit_register <= `NHP_TX_RESET;
      tone_tx_load <= 1'b0;
    end else if (pd_s) begin
      control_register <= `NHP_CR_RESET;
      tone_transmit_register <= `NHP_TX_RESET;
      tone_tx_load <= 1'b0;
    end else begin
      tone_tx_load <= do_write & sel_tone;
      if (do_write && sel_ctrl) begin
        control_register <= write_data;
      end
      if (do_write && sel_tone) begin
        tone_transmit_register <= write_data;
      end
    end
  end

  // ----------------------------------------
  // Control bit outputs
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tone_transmit_enable <= 1'b0;
      detect_output_enable <= 1'b0;
      tone_gen_analog_out <= 1'b0;
    end else begin
      // Copies trail the register by one cycle
      tone_transmit_enable <= control_register[`NHP_CR_TONE_EN];
      detect_output_enable <= control_register[`NHP_CR_DET_EN];
      tone_gen_analog_out <= ~pd_s & control_register[`NHP_CR_TONE_EN];
    end
  end

  // ----------------------------------------
  // Call tone detect pin
  // ----------------------------------------
  // Detector is on clk already, no synchroniser
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      call_tone_detect_out <= 1'b0;
    end else if (pd_s) begin
      call_tone_detect_out <= 1'b0;
    end else if (!control_register[`NHP_CR_DET_EN]) begin
      call_tone_detect_out <= 1'b0;
    end else begin
      call_tone_detect_out <= call_tone_valid;
    end
  end

endmodule

`default_nettype wire

// ===== core/nhp_defs.vh
// Constants shared by the nibble host port files.
// Assumes it is included by bare name from the core files only.
`ifndef NHP_DEFS_VH
`define NHP_DEFS_VH

// ----------------------------------------
// Bus widths
// ----------------------------------------
`define NHP_DATA_W 4
`define NHP_ADDR_W 2
`define NHP_FLAG_W 3

// ----------------------------------------
// Register addresses, separate-strobe style
// ----------------------------------------
`define NHP_ADDR_TONE 2'h0
`define NHP_ADDR_CTRL 2'h1

// ----------------------------------------
// Host styles, strap level
// ----------------------------------------
`define NHP_STYLE_STROBE 1'b1
`define NHP_STYLE_CLOCKED 1'b0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define NHP_CR_TONE_EN 0
`define NHP_CR_DET_EN 1
`define NHP_STR_DET 0

// ----------------------------------------
// Reset and idle values
// ----------------------------------------
`define NHP_CR_RESET 4'h0
`define NHP_TX_RESET 4'h0
`define NHP_READ_IDLE 4'h0
`define NHP_ADDR_RESET 2'h0

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define NHP_SETTLE_CYCLES 2'h3

`endif

// ===== core/nhp_sync.v
// Two-flop synchroniser, one lane per bit.
// Assumes inputs are asynchronous pins; outputs are in the clk domain.
`timescale 1ns/100ps
`default_nettype none

module nhp_sync #(
  parameter W = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire sys_rst,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  // ----------------------------------------
  // Per-bit two stage chain
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      reg meta;
      reg stable;
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta <= RESET_VAL[i];
          stable <= RESET_VAL[i];
        end else begin
          meta <= async_in[i];
          stable <= meta;
        end
      end
      assign sync_out[i] = stable;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== core/nhp_edge.v
// Edge finder for an already synchronised level.
// Assumes the input is in the clk domain; pulses last one cycle.
`timescale 1ns/100ps
`default_nettype none

module nhp_edge #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk,
  input wire sys_rst,
  input wire level,
  output wire rise,
  output wire fall
);

  // ----------------------------------------
  // Previous value
  // ----------------------------------------
  reg last;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last <= RESET_VAL;
    end else begin
      last <= level;
    end
  end

  assign rise = level & ~last;
  assign fall = ~level & last;

endmodule

`default_nettype wire

// ===== sim/nhp_port_monitor.sv
// Checker on the ports of nhp_port, bound at the foot of this file.
// Assumes one clk domain and a pin lag of three clocks.
`timescale 1ns/100ps
`default_nettype none
module nhp_port_monitor (
  input wire clk,
  input wire sys_rst,
  input wire power_down_input,
  input wire cs_n,
  input wire read_n,
  input wire wr_n,
  input wire data_oe,
  input wire call_tone_valid,
  input wire [3:0] control_register,
  input wire [3:0] tone_transmit_register,
  input wire tone_tx_load,
  input wire tone_gen_analog_out,
  input wire call_tone_detect_out,
  input wire style_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------
  // Read drive
  // ------
  sequence sep_rd_s;
    (style_strobe && !cs_n && !read_n) [*4];
  endsequence
  sequence clk_rd_s;
    (!style_strobe && !cs_n && wr_n && read_n) [*4];
  endsequence
  sep_read_a: assert property (sep_rd_s |-> data_oe)
    else $error("strobe read undriven");
  clk_read_a: assert property (clk_rd_s |-> data_oe)
    else $error("clocked read undriven");
  // Idle level differs per style, so one compare covers both
  rd_release_a: assert property ((read_n == style_strobe) [*4] |-> !data_oe)
    else $error("bus not released");
  // ------
  // Writes and outputs
  // ------
  cs_quiet_a: assert property (cs_n [*5] |-> !data_oe && !tone_tx_load)
    else $error("activity while deselected");
  load_pulse_a: assert property (tone_tx_load |=> !tone_tx_load)
    else $error("load pulse too long");
  pd_clear_a: assert property (power_down_input [*5] |-> control_register == 4'h0
    && tone_transmit_register == 4'h0 && !call_tone_detect_out && !tone_gen_analog_out)
    else $error("power down not clearing");
  det_gate_a: assert property (!control_register[1] |=> !call_tone_detect_out)
    else $error("detect out not gated");
  det_on_a: assert property ((!power_down_input && control_register[1]
    && call_tone_valid) [*3] |=> call_tone_detect_out) else $error("detect out missing");
  tone_off_a: assert property (!control_register[0] |=> !tone_gen_analog_out)
    else $error("tone out not off");
endmodule
bind nhp_port nhp_port_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
  .power_down_input(power_down_input), .cs_n(cs_n), .read_n(read_n), .wr_n(wr_n),
  .data_oe(data_oe), .call_tone_valid(call_tone_valid), .control_register(control_register),
  .tone_transmit_register(tone_transmit_register), .tone_tx_load(tone_tx_load),
  .tone_gen_analog_out(tone_gen_analog_out), .call_tone_detect_out(call_tone_detect_out),
  .style_strobe(style_strobe));
`default_nettype wire

// ===== sim/nhp_host_model.sv
// Host microcontroller model driving the nibble port pins.
// Assumes bus is the resolved data wire; called at falling clk.
`timescale 1ns/100ps
`default_nettype none
module nhp_host_model (
  input wire logic clk,
  input wire logic [3:0] bus,
  output logic cs_n,
  output logic read_n,
  output logic ale,
  output logic wr_n,
  output logic [3:0] d
);
  // ------
  // Bus cycles, strobe halves of four clocks, separate-style read or write strobe low for six
  // ------
  initial begin
    cs_n = 1'b1;
    read_n = 1'b1;
    ale = 1'b0;
    wr_n = 1'b1;
    d = 4'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Released lines show the inverse, never a stale value
  task automatic sep_op(input logic [1:0] a, input logic rd, input logic [3:0] v,
      input logic cs, output logic [3:0] q);
    d = {2'h0, a};
    ale = 1'b1;
    tick(4);
    ale = 1'b0;
    tick(4);
    cs_n = cs;
    d = v;
    if (rd) read_n = 1'b0;
    else wr_n = 1'b0;
    tick(6);
    q = bus;
    read_n = 1'b1;
    wr_n = 1'b1;
    tick(4);
    cs_n = 1'b1;
    d = ~v;
    tick(1);
  endtask
  // Strobe clock pulses only per transfer
  task automatic clk_op(input logic sel, input logic rd, input logic [3:0] v,
      output logic [3:0] q);
    cs_n = 1'b0;
    wr_n = rd;
    ale = sel;
    d = v;
    tick(4);
    q = bus;
    read_n = 1'b0;
    tick(3);
    cs_n = 1'b1;
    wr_n = 1'b1;
    d = ~v;
    tick(1);
    read_n = 1'b1;
    tick(4);
  endtask
endmodule
`default_nettype wire

// ===== sim/nhp_port_tb_top.sv
// Self-checking bench for nhp_port with the host model on its pins.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module nhp_port_tb_top;
  logic clk, sys_rst, strap, pd, valid;
  logic [2:0] flags;
  logic [3:0] rx, q;
  wire cs_n, read_n, ale, wr_n, data_oe, det_en, tone_out, det_out, style, load, tx_en;
  wire [3:0] d_host, d_out, cr, tx, bus;
  int fail_count = 0;
  int samples_checked = 0;
  int loads = 0;
  assign bus = data_oe ? d_out : d_host;
  always @(posedge clk) begin
    if (load === 1'b1) loads <= loads + 1;
  end
  nhp_port dut (.clk(clk), .sys_rst(sys_rst), .host_style_strap(strap),
    .power_down_input(pd), .cs_n(cs_n), .read_n(read_n), .ale(ale), .wr_n(wr_n),
    .data_in(bus), .data_out(d_out), .data_oe(data_oe), .call_tone_valid(valid),
    .status_flags(flags), .tone_receive_register(rx), .control_register(cr),
    .tone_transmit_register(tx), .tone_tx_load(load), .tone_transmit_enable(tx_en),
    .detect_output_enable(det_en), .tone_gen_analog_out(tone_out),
    .call_tone_detect_out(det_out), .style_strobe(style));
  nhp_host_model host (.clk(clk), .bus(bus), .cs_n(cs_n), .read_n(read_n), .ale(ale),
    .wr_n(wr_n), .d(d_host));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    sys_rst = 1'b1;
    strap = s;
    host.tick(5);
    sys_rst = 1'b0;
    host.tick(8);
    check("style", {3'h0, style}, {3'h0, s});
  endtask
  task automatic sc_strobe;
    host.sep_op(2'h1, 1'b0, 4'h3, 1'b0, q);
    check("ctrl", cr, 4'h3);
    check("det_en", {3'h0, det_en}, 4'h1);
    host.sep_op(2'h1, 1'b1, 4'h0, 1'b0, q);
    check("status", q, {flags, valid});
    host.sep_op(2'h0, 1'b0, 4'h9, 1'b0, q);
    check("tone_reg", tx, 4'h9);
    check("loads", loads[3:0], 4'h1);
    host.sep_op(2'h0, 1'b1, 4'h0, 1'b0, q);
    check("receive", q, rx);
    host.sep_op(2'h1, 1'b0, 4'h0, 1'b1, q);
    check("cs_high", cr, 4'h3);
    host.sep_op(2'h2, 1'b0, 4'hc, 1'b0, q);
    check("unmapped", tx, 4'h9);
    check("no_load", loads[3:0], 4'h1);
  endtask
  task automatic sc_detect;
    check("detect_on", {3'h0, det_out}, 4'h1);
    host.sep_op(2'h1, 1'b0, 4'h1, 1'b0, q);
    check("detect_gated", {3'h0, det_out}, 4'h0);
    check("tone_on", {3'h0, tone_out}, 4'h1);
    check("tone_en", {3'h0, tx_en}, 4'h1);
    host.sep_op(2'h1, 1'b0, 4'h2, 1'b0, q);
    check("tone_off", {3'h0, tone_out}, 4'h0);
    check("tone_en_off", {3'h0, tx_en}, 4'h0);
    valid = 1'b0;
    host.tick(3);
    check("detect_off", {3'h0, det_out}, 4'h0);
    valid = 1'b1;
    host.tick(3);
    check("detect_back", {3'h0, det_out}, 4'h1);
  endtask
  task automatic sc_power;
    pd = 1'b1;
    host.sep_op(2'h1, 1'b1, 4'h0, 1'b0, q);
    check("pd_status", q, 4'h0);
    check("pd_ctrl", cr, 4'h0);
    check("pd_tone", tx, 4'h0);
    check("pd_detect", {3'h0, det_out}, 4'h0);
    pd = 1'b0;
    host.tick(4);
  endtask
  task automatic sc_clocked;
    do_reset(1'b0);
    host.clk_op(1'b1, 1'b0, 4'h3, q);
    check("clk_ctrl", cr, 4'h3);
    host.clk_op(1'b0, 1'b0, 4'ha, q);
    check("clk_tone", tx, 4'ha);
    check("clk_load", loads[3:0], 4'h2);
    host.clk_op(1'b1, 1'b1, 4'h0, q);
    check("clk_status", q, {flags, valid});
    host.clk_op(1'b0, 1'b1, 4'h0, q);
    check("clk_receive", q, rx);
  endtask
  initial begin
    sys_rst = 1'b1;
    strap = 1'b1;
    pd = 1'b0;
    valid = 1'b1;
    flags = 3'h5;
    rx = 4'h6;
    do_reset(1'b1);
    sc_strobe();
    sc_detect();
    sc_power();
    sc_clocked();
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
